// [core_model.sv]
`timescale 1ns/100ps
`default_nettype none
// core side: wait instructions, handler state, wake sources
module core_model (
  input  wire logic       clk_i,
  output logic            sleep_req_o,
  output logic            deep_o,
  output logic            exit_o,
  output logic            handler_o,
  output logic            lf_off_o,
  output logic            ulf_o,
  output logic            ext_o,
  output logic [10:0]     wake_o
);
  initial begin
    {sleep_req_o, deep_o, exit_o, handler_o, lf_off_o, ulf_o, ext_o} = 7'h00;
    wake_o = 11'h000;
  end
  // level settings, held until the next call
  task automatic levels(input logic exit_v, input logic handler_v, input logic ulf_v, input logic ext_v,
                        input logic lf_v);
    @(posedge clk_i);
    exit_o <= exit_v;
    handler_o <= handler_v;
    ulf_o <= ulf_v;
    ext_o <= ext_v;
    lf_off_o <= lf_v;
    #1;
  endtask
  // branches off a cycle before the wait instruction
  task automatic sleep(input logic deep, input logic lf_off);
    @(posedge clk_i);
    deep_o <= deep;
    lf_off_o <= lf_off;
    @(posedge clk_i);
    sleep_req_o <= 1'b1;
    @(posedge clk_i);
    sleep_req_o <= 1'b0;
    #1;
  endtask
  // one-cycle wake source pulse
  task automatic pulse(input int idx);
    @(posedge clk_i);
    wake_o[idx] <= 1'b1;
    @(posedge clk_i);
    wake_o[idx] <= 1'b0;
    #1;
  endtask
endmodule // core_model
`default_nettype wire

// [energy_mode_entry_exit_control.sv]
`timescale 1ns/100ps
`default_nettype none
module energy_mode_entry_exit_control (
  input  wire logic                            clk_i,
  input  wire logic                            rst_n_i,
  input  wire logic                            ce_i,
  input  wire logic [energy_pkg::ADDR_W-1:0]   avs_address_i,
  input  wire logic                            avs_read_i,
  input  wire logic                            avs_write_i,
  input  wire logic [energy_pkg::DATA_W-1:0]   avs_writedata_i,
  input  wire logic [3:0]                      avs_byteenable_i,
  output logic      [energy_pkg::DATA_W-1:0]   avs_readdata_o,
  output logic                                 avs_waitrequest_o,
  input  wire logic                            sleep_req_i,
  input  wire logic                            deep_sleep_i,
  input  wire logic                            sleep_on_exit_i,
  input  wire logic                            handler_active_i,
  input  wire logic                            lf_branches_off_i,
  input  wire logic                            ultra_slow_sel_i,
  input  wire logic                            pulse_counter_ext_clk_i,
  input  wire logic                            other_irq_wake_i,
  input  wire logic                            rtc_wake_i,
  input  wire logic                            low_energy_serial_port_wake_i,
  input  wire logic                            i2c_addr_wake_i,
  input  wire logic                            pulse_counter_wake_i,
  input  wire logic                            analog_comparator_edge_wake_i,
  input  wire logic                            supply_comparator_edge_wake_i,
  input  wire logic                            pin_irq_wake_i,
  input  wire logic                            shutoff_pin_wake_i,
  input  wire logic                            pin_reset_i,
  input  wire logic                            power_cycle_i,
  output energy_pkg::state_e                   energy_state_o,
  output logic                                 core_run_o,
  output logic                                 hf_osc_on_o,
  output logic                                 lf_clk_on_o,
  output logic                                 core_reg_on_o,
  output logic                                 reg_full_drive_o
);
  import energy_pkg::*;

  typedef struct packed {
    state_e      st;
    state_e      tgt;
    logic        vreg;
    logic        block;
    logic [1:0]  seq_field;
    logic [3:0]  seq_cnt;
    logic        locked;
    logic        aux;
    logic        wait_n;
    logic [31:0] rdata;
    logic        core_run;
    logic        hf_on;
    logic        lf_on;
    logic        reg_on;
    logic        full_drive;
  } regs_s;

  regs_s q, d;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        take;
  logic        wr_take;
  logic        ctrl_wr;
  logic [1:0]  wr_seq;
  logic        seq_ok;
  logic        seq_done;
  logic        reset_src;
  logic        wake_ok;
  logic        sleep_take;
  logic        defer;
  logic [31:0] rd_val;
  state_e      pick;

  assign take      = ce_i && q.wait_n && (avs_read_i || avs_write_i);
  assign wr_take   = take && avs_write_i;
  assign ctrl_wr   = wr_take && (avs_address_i == OFF_CTRL) && avs_byteenable_i[0] && !q.locked;
  assign wr_seq    = avs_writedata_i[SEQ_MSB:SEQ_LSB];
  assign seq_ok    = (wr_seq == (q.seq_cnt[0] ? SEQ_ODD_VAL : SEQ_EVEN_VAL));
  assign seq_done  = ctrl_wr && seq_ok && (q.seq_cnt == SEQ_LAST_IDX) && (q.st == ST_ACTIVE);
  assign reset_src = pin_reset_i || power_cycle_i;

  ////////////////////////////////////////////////////////////////////////////
  // target decode

  always_comb begin
    if (!deep_sleep_i || q.block || q.vreg) begin
      pick = ST_LIGHT;
    end else if (lf_branches_off_i) begin
      pick = ST_STOP;
    end else begin
      pick = ST_DEEP;
    end
  end

  assign sleep_take = ce_i && sleep_req_i && (q.st == ST_ACTIVE) && !seq_done && !reset_src;
  assign defer      = sleep_on_exit_i && handler_active_i;

  ////////////////////////////////////////////////////////////////////////////
  // wakeup qualification

  always_comb begin
    unique case (q.st)
      ST_LIGHT: wake_ok = other_irq_wake_i || rtc_wake_i || low_energy_serial_port_wake_i || i2c_addr_wake_i
                          || pulse_counter_wake_i || analog_comparator_edge_wake_i || supply_comparator_edge_wake_i
                          || pin_irq_wake_i;
      ST_DEEP: wake_ok = rtc_wake_i || low_energy_serial_port_wake_i || i2c_addr_wake_i || pulse_counter_wake_i
                         || analog_comparator_edge_wake_i || supply_comparator_edge_wake_i || pin_irq_wake_i;
      ST_STOP: wake_ok = i2c_addr_wake_i || analog_comparator_edge_wake_i || supply_comparator_edge_wake_i || pin_irq_wake_i
                         || (rtc_wake_i && ultra_slow_sel_i)
                         || (pulse_counter_wake_i && pulse_counter_ext_clk_i);
      ST_SHUTOFF: wake_ok = shutoff_pin_wake_i;
      default: wake_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    rd_val = DATA_ZERO;
    unique case (avs_address_i)
      OFF_CTRL: begin
        rd_val[VREG_BIT]        = q.vreg;
        rd_val[BLOCK_BIT]       = q.block;
        rd_val[SEQ_MSB:SEQ_LSB] = q.seq_field;
      end
      OFF_LOCK:   rd_val[LOCK_BIT] = q.locked;
      OFF_AUX:    rd_val[AUX_BIT]  = q.aux;
      OFF_STATUS: begin
        rd_val[STAT_ST_MSB:STAT_ST_LSB]   = q.st;
        rd_val[STAT_CNT_MSB:STAT_CNT_LSB] = q.seq_cnt;
        rd_val[STAT_LOCK_BIT]             = q.locked;
      end
      default: rd_val = DATA_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    if (ce_i) begin
      // bus handshake: one cycle of waitrequest low per access
      if (take) begin
        d.wait_n = 1'b0;
        d.rdata  = avs_read_i ? rd_val : DATA_ZERO;
      end else begin
        d.wait_n = 1'b1;
      end
      if (ctrl_wr) begin
        d.vreg      = avs_writedata_i[VREG_BIT];
        d.block     = avs_writedata_i[BLOCK_BIT];
        d.seq_field = wr_seq;
        if (wr_seq == SEQ_RESTART) begin
          d.seq_cnt = CNT_RST;
        end else if (seq_ok) begin
          d.seq_cnt = q.seq_cnt + SEQ_CNT_ONE;
        end else begin
          d.seq_cnt = CNT_RST;
        end
      end
      if (wr_take && (avs_address_i == OFF_LOCK) && (&avs_byteenable_i[1:0])) begin
        d.locked = (avs_writedata_i[KEY_MSB:0] != UNLOCK_KEY);
      end
      if (wr_take && (avs_address_i == OFF_AUX) && avs_byteenable_i[0] && !q.locked) begin
        d.aux = avs_writedata_i[AUX_BIT];
      end
      unique case (q.st)
        ST_ACTIVE: begin
          if (seq_done) begin
            d.st      = ST_SHUTOFF;
            d.seq_cnt = CNT_RST;
          end else if (sleep_take) begin
            d.tgt = pick;
            d.st  = defer ? ST_PENDING : pick;
          end
        end
        ST_PENDING: begin
          if (!handler_active_i) begin
            d.st = q.tgt;
          end
        end
        ST_LIGHT, ST_DEEP, ST_STOP: begin
          if (wake_ok) begin
            d.st = ST_ACTIVE;
          end
        end
        ST_SHUTOFF: begin
          if (wake_ok) begin
            d           = '0; // register contents lost in shutoff
            d.st        = ST_ACTIVE;
            d.tgt       = ST_ACTIVE;
            d.wait_n    = 1'b1;
          end
        end
        default: d.st = ST_ACTIVE;
      endcase
      if (reset_src) begin
        d        = '0;
        d.st     = ST_ACTIVE;
        d.tgt    = ST_ACTIVE;
        d.wait_n = 1'b1;
      end
      d.core_run   = (d.st == ST_ACTIVE) || (d.st == ST_PENDING);
      d.hf_on      = d.core_run || (d.st == ST_LIGHT);
      d.reg_on     = d.hf_on;
      d.lf_on      = (d.st != ST_STOP) && (d.st != ST_SHUTOFF);
      d.full_drive = ((d.st == ST_DEEP) || (d.st == ST_STOP)) ? d.vreg : d.reg_on;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q            <= '0;
      q.st         <= ST_ACTIVE;
      q.tgt        <= ST_ACTIVE;
      q.vreg       <= VREG_RST;
      q.block      <= BLOCK_RST;
      q.seq_field  <= SEQ_RST;
      q.seq_cnt    <= CNT_RST;
      q.locked     <= LOCK_RST;
      q.aux        <= AUX_RST;
      q.wait_n     <= 1'b1;
      q.core_run   <= 1'b1;
      q.hf_on      <= 1'b1;
      q.reg_on     <= 1'b1;
      q.lf_on      <= 1'b1;
      q.full_drive <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata_o    = q.rdata;
  assign avs_waitrequest_o = q.wait_n;
  assign energy_state_o    = q.st;
  assign core_run_o        = q.core_run;
  assign hf_osc_on_o       = q.hf_on;
  assign lf_clk_on_o       = q.lf_on;
  assign core_reg_on_o     = q.reg_on;
  assign reg_full_drive_o  = q.full_drive;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_req_plain;
    sleep_take && !defer;
  endsequence

  sequence s_good_write;
    ctrl_wr && seq_ok && !reset_src;
  endsequence

  a_wait_light_entry: assert property (s_req_plain ##0 !deep_sleep_i |=> q.st == ST_LIGHT)
    else $error("wait without deep setting did not give light sleep");

  a_deep_entry_sel: assert property (s_req_plain ##0 (deep_sleep_i && !q.vreg && !q.block
                                     && !lf_branches_off_i) |=> q.st == ST_DEEP)
    else $error("deep sleep not selected");

  a_block_forces_light: assert property (s_req_plain ##0 q.block |=> q.st == ST_LIGHT)
    else $error("block bit did not force light sleep");

  a_hold_keeps_reg: assert property (s_req_plain ##0 q.vreg |=> q.st == ST_LIGHT ##0 core_reg_on_o)
    else $error("regulator hold did not keep regulator on");

  a_no_spont_entry: assert property (ce_i && q.st == ST_ACTIVE && !sleep_req_i && !seq_done
                                     |=> q.st inside {ST_ACTIVE, ST_PENDING})
    else $error("low energy entry without wait instruction");

  a_exit_holdoff: assert property (sleep_take && defer ##1 handler_active_i
                                   |-> q.st == ST_PENDING)
    else $error("entry not held while handler active");

  a_shutoff_done: assert property (seq_done && !reset_src |=> q.st == ST_SHUTOFF ##0 !core_run_o)
    else $error("ninth sequence write did not enter shutoff");

  a_zero_restart: assert property (ctrl_wr && wr_seq == SEQ_RESTART && !reset_src
                                   |=> q.seq_cnt == CNT_RST)
    else $error("zero write did not restart sequence");

  a_wrong_discard: assert property (ctrl_wr && !seq_ok && !reset_src |=> q.seq_cnt == CNT_RST)
    else $error("bad sequence write kept progress");

  a_seq_advance: assert property (s_good_write ##0 q.seq_cnt != SEQ_LAST_IDX
                                  |=> q.seq_cnt == $past(q.seq_cnt) + SEQ_CNT_ONE)
    else $error("sequence progress did not advance");

  a_wake_to_active: assert property (ce_i && wake_ok && q.st inside {ST_LIGHT, ST_DEEP, ST_STOP, ST_SHUTOFF}
                                     |=> q.st == ST_ACTIVE)
    else $error("wakeup did not return to active");

  a_reset_to_active: assert property (ce_i && reset_src |=> q.st == ST_ACTIVE && q.seq_cnt == CNT_RST)
    else $error("reset source did not return to active");

  a_deep_filters: assert property (ce_i && q.st == ST_DEEP && other_irq_wake_i && !wake_ok && !reset_src
                                   |=> q.st == ST_DEEP)
    else $error("deep sleep woke on disallowed source");

  a_stop_rtc_gate: assert property (ce_i && q.st == ST_STOP && !wake_ok && !reset_src
                                    |=> q.st == ST_STOP ##0 !lf_clk_on_o)
    else $error("stop woke on disallowed source");

  a_shutoff_hold: assert property (ce_i && q.st == ST_SHUTOFF && !shutoff_pin_wake_i && !reset_src
                                   |=> q.st == ST_SHUTOFF)
    else $error("shutoff left without allowed wakeup");

  a_drive_code: assert property (q.st inside {ST_DEEP, ST_STOP} |-> reg_full_drive_o == q.vreg)
    else $error("regulator drive does not follow hold bit");

  a_reserved_zero: assert property (take && avs_read_i && avs_address_i == OFF_CTRL
                                    |=> avs_readdata_o[DATA_W-1:SEQ_MSB+1] == '0 && !avs_waitrequest_o)
    else $error("reserved control bits not zero");

endmodule // energy_mode_entry_exit_control
`default_nettype wire

// [energy_pkg.sv]
`default_nettype none
package energy_pkg;
  // bus geometry
  localparam int          ADDR_W        = 6;
  localparam int          DATA_W        = 32;
  localparam logic [5:0]  OFF_CTRL      = 6'h00;
  localparam logic [5:0]  OFF_LOCK      = 6'h08;
  localparam logic [5:0]  OFF_AUX       = 6'h24;
  localparam logic [5:0]  OFF_STATUS    = 6'h30;

  // control, aux and lock register fields
  localparam int          VREG_BIT      = 0;
  localparam int          BLOCK_BIT     = 1;
  localparam int          SEQ_LSB       = 2;
  localparam int          SEQ_MSB       = 3;
  localparam int          AUX_BIT       = 0;
  localparam int          LOCK_BIT      = 0;
  localparam int          KEY_MSB       = 15;

  // status register fields
  localparam int          STAT_ST_LSB   = 0;
  localparam int          STAT_ST_MSB   = 2;
  localparam int          STAT_CNT_LSB  = 4;
  localparam int          STAT_CNT_MSB  = 7;
  localparam int          STAT_LOCK_BIT = 8;

  // shutoff write sequence
  localparam logic [1:0]  SEQ_RESTART   = 2'h0;
  localparam logic [1:0]  SEQ_EVEN_VAL  = 2'h2;
  localparam logic [1:0]  SEQ_ODD_VAL   = 2'h3;
  localparam logic [3:0]  SEQ_LAST_IDX  = 4'h8;
  localparam logic [3:0]  SEQ_CNT_ONE   = 4'h1;

  // lock key
  localparam logic [15:0] UNLOCK_KEY    = 16'hade8;

  // reset values
  localparam logic        VREG_RST      = 1'h0;
  localparam logic        BLOCK_RST     = 1'h0;
  localparam logic [1:0]  SEQ_RST       = 2'h0;
  localparam logic [3:0]  CNT_RST       = 4'h0;
  localparam logic        LOCK_RST      = 1'h0;
  localparam logic        AUX_RST       = 1'h0;
  localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_ACTIVE  = 3'h0,
    ST_PENDING = 3'h1,
    ST_LIGHT   = 3'h3,
    ST_DEEP    = 3'h2,
    ST_STOP    = 3'h6,
    ST_SHUTOFF = 3'h4
  } state_e;
endpackage
`default_nettype wire

// [tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
  import energy_pkg::*;
  logic clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [5:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rdata;
  logic sleep_req_i, deep_sleep_i, sleep_on_exit_i, handler_active_i;
  logic lf_branches_off_i, ultra_slow_sel_i, pulse_counter_ext_clk_i;
  logic core_run_o, hf_osc_on_o, lf_clk_on_o, core_reg_on_o, reg_full_drive_o, ce_i;
  logic [3:0] avs_byteenable_i;
  logic [10:0] wk;
  state_e energy_state_o;
  int num_errors = 0;
  int checked = 0;

  energy_mode_entry_exit_control dut (.clk_i, .rst_n_i, .ce_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .sleep_req_i, .deep_sleep_i, .sleep_on_exit_i, .handler_active_i, .lf_branches_off_i,
    .ultra_slow_sel_i, .pulse_counter_ext_clk_i, .other_irq_wake_i(wk[0]), .rtc_wake_i(wk[1]),
    .low_energy_serial_port_wake_i(wk[2]), .i2c_addr_wake_i(wk[3]), .pulse_counter_wake_i(wk[4]), .analog_comparator_edge_wake_i(wk[5]),
    .supply_comparator_edge_wake_i(wk[6]), .pin_irq_wake_i(wk[7]), .shutoff_pin_wake_i(wk[8]), .pin_reset_i(wk[9]),
    .power_cycle_i(wk[10]), .energy_state_o, .core_run_o, .hf_osc_on_o, .lf_clk_on_o, .core_reg_on_o,
    .reg_full_drive_o);
  core_model core (.clk_i(clk_i), .sleep_req_o(sleep_req_i), .deep_o(deep_sleep_i),
    .exit_o(sleep_on_exit_i), .handler_o(handler_active_i), .lf_off_o(lf_branches_off_i),
    .ulf_o(ultra_slow_sel_i), .ext_o(pulse_counter_ext_clk_i), .wake_o(wk));

  initial clk_i = 1'b0;
  always #50 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_st(input state_e exp);
    checked++;
    if (energy_state_o !== exp) begin
      num_errors++;
      $display("wrong value at %0t: state %h expected %h", $time, energy_state_o, exp);
    end
  endtask
  // one avalon access, held until waitrequest sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 50) cmp32(32'hffff_ffff, 32'h0);
  endtask
  task automatic seq_cnt_zero();
    bus(1'b0, OFF_STATUS, 32'h0);
    cmp32({28'h0, rdata[STAT_CNT_MSB:STAT_CNT_LSB]}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    bus(1'b0, OFF_CTRL, 32'h0);
    cmp32(rdata, 32'h0);
    bus(1'b0, 6'h3c, 32'h0);
    cmp32(rdata, 32'h0);
    bus(1'b1, OFF_CTRL, 32'h0000_000f);
    bus(1'b0, OFF_CTRL, 32'h0);
    cmp32(rdata, 32'h0000_000f);
    bus(1'b1, OFF_CTRL, 32'h0);
    cmp_st(ST_ACTIVE);
    $display("test regs done");
  endtask
  task automatic t_light_deep();
    core.sleep(1'b0, 1'b0);
    cmp_st(ST_LIGHT);
    cmp32({31'h0, core_run_o}, 32'h0);
    core.pulse(0);
    cmp_st(ST_ACTIVE);
    core.sleep(1'b1, 1'b0);
    cmp_st(ST_DEEP);
    cmp32({30'h0, hf_osc_on_o, reg_full_drive_o}, 32'h0);
    bus(1'b1, OFF_CTRL, 32'h0000_0001);
    cmp32({31'h0, reg_full_drive_o}, 32'h1);
    cmp_st(ST_DEEP);
    bus(1'b1, OFF_CTRL, 32'h0);
    core.pulse(0);
    cmp_st(ST_DEEP);
    core.pulse(1);
    cmp_st(ST_ACTIVE);
    $display("test light and deep done");
  endtask
  task automatic t_block_hold();
    bus(1'b1, OFF_CTRL, 32'h0000_0002);
    core.sleep(1'b1, 1'b0);
    cmp_st(ST_LIGHT);
    core.pulse(0);
    bus(1'b1, OFF_CTRL, 32'h0000_0001);
    core.sleep(1'b1, 1'b0);
    cmp_st(ST_LIGHT);
    cmp32({31'h0, core_reg_on_o}, 32'h1);
    core.pulse(9);
    cmp_st(ST_ACTIVE);
    bus(1'b0, OFF_CTRL, 32'h0);
    cmp32(rdata, 32'h0);
    $display("test block and hold done");
  endtask
  task automatic t_stop();
    core.sleep(1'b1, 1'b1);
    cmp_st(ST_STOP);
    cmp32({31'h0, lf_clk_on_o}, 32'h0);
    core.pulse(4);
    cmp_st(ST_STOP);
    core.pulse(1);
    cmp_st(ST_STOP);
    core.levels(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    core.pulse(4);
    cmp_st(ST_ACTIVE);
    core.levels(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    core.sleep(1'b1, 1'b1);
    core.pulse(1);
    cmp_st(ST_ACTIVE);
    core.sleep(1'b1, 1'b1);
    core.pulse(3);
    cmp_st(ST_ACTIVE);
    core.levels(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    $display("test stop done");
  endtask
  task automatic t_exit();
    int n;
    n = 0;
    core.levels(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    core.sleep(1'b0, 1'b0);
    cmp_st(ST_PENDING);
    core.levels(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    while (energy_state_o === ST_PENDING && n < 5) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    cmp_st(ST_LIGHT);
    core.pulse(0);
    core.levels(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    $display("test exit done");
  endtask
  task automatic t_shutoff();
    bus(1'b1, OFF_CTRL, 32'h8);
    bus(1'b1, OFF_CTRL, 32'hc);
    bus(1'b1, OFF_CTRL, 32'h0);
    seq_cnt_zero();
    bus(1'b1, OFF_CTRL, 32'h8);
    bus(1'b1, OFF_CTRL, 32'hc);
    bus(1'b1, OFF_CTRL, 32'h4);
    seq_cnt_zero();
    cmp_st(ST_ACTIVE);
    for (int i = 0; i < 9; i++) bus(1'b1, OFF_CTRL, (i % 2) ? 32'hc : 32'h8);
    #1;
    cmp_st(ST_SHUTOFF);
    core.pulse(7);
    cmp_st(ST_SHUTOFF);
    core.pulse(8);
    cmp_st(ST_ACTIVE);
    for (int i = 0; i < 9; i++) bus(1'b1, OFF_CTRL, (i % 2) ? 32'hc : 32'h8);
    #1;
    cmp_st(ST_SHUTOFF);
    core.pulse(10);
    cmp_st(ST_ACTIVE);
    bus(1'b0, OFF_CTRL, 32'h0);
    cmp32(rdata, 32'h0);
    $display("test shutoff done");
  endtask
  task automatic t_freeze();
    @(posedge clk_i);
    ce_i <= 1'b0;
    core.sleep(1'b0, 1'b0);
    cmp_st(ST_ACTIVE);
    @(posedge clk_i);
    ce_i <= 1'b1;
    core.sleep(1'b0, 1'b0);
    cmp_st(ST_LIGHT);
    @(posedge clk_i);
    ce_i <= 1'b0;
    core.pulse(0);
    cmp_st(ST_LIGHT);
    @(posedge clk_i);
    ce_i <= 1'b1;
    core.pulse(0);
    cmp_st(ST_ACTIVE);
    $display("test clock enable done");
  endtask
  task automatic t_lock();
    @(posedge clk_i);
    avs_byteenable_i <= 4'he;
    bus(1'b1, OFF_CTRL, 32'h0000_0002);
    avs_byteenable_i <= 4'hf;
    bus(1'b0, OFF_CTRL, 32'h0);
    cmp32(rdata, 32'h0);
    bus(1'b1, OFF_LOCK, 32'h0);
    bus(1'b1, OFF_CTRL, 32'h0000_0002);
    bus(1'b0, OFF_LOCK, 32'h0);
    cmp32(rdata, 32'h1);
    bus(1'b0, OFF_CTRL, 32'h0);
    cmp32(rdata, 32'h0);
    bus(1'b1, OFF_LOCK, {16'h0, UNLOCK_KEY});
    bus(1'b1, OFF_CTRL, 32'h0000_0002);
    bus(1'b0, OFF_CTRL, 32'h0);
    cmp32(rdata, 32'h0000_0002);
    bus(1'b1, OFF_CTRL, 32'h0);
    $display("test lock done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_i = 1'b0;
    {avs_read_i, avs_write_i} = 2'h0;
    avs_address_i = 6'h00;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    ce_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_light_deep();
    t_block_hold();
    t_stop();
    t_exit();
    t_freeze();
    t_lock();
    t_shutoff();
    wrap_up();
  end
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
endmodule // tb
`default_nettype wire
